// ### rtl/tim_pkg.sv
// constants for the timer interrupt mask logic
package tim_pkg;

    // bus geometry
    localparam int          TIM_ADDR_W     = 4;
    localparam int          TIM_DATA_W     = 32;
    localparam int          TIM_REG_W      = 16;

    // register byte offsets
    localparam logic [3:0]  TIM_OFF_MASK   = 4'h0;
    localparam logic [3:0]  TIM_OFF_STAT   = 4'h4;
    localparam logic [3:0]  TIM_OFF_IMASK  = 4'h8;
    localparam logic [3:0]  TIM_OFF_REQ    = 4'hC;

    // field positions, shared by mask, flag, request, status and interrupt mask words
    localparam int          TIM_B_SHARED   = 15;
    localparam int          TIM_B_CMP_HI   = 14;
    localparam int          TIM_B_CMP_LO   = 11;
    localparam int          TIM_B_CAP_HI   = 10;
    localparam int          TIM_B_CAP_LO   = 8;
    localparam int          TIM_B_CWRAP    = 7;
    localparam int          TIM_B_AWRAP    = 5;
    localparam int          TIM_B_AEDGE    = 4;
    localparam int          TIM_B_CLKOUT   = 3;
    localparam int          TIM_B_PRE_HI   = 2;
    localparam int          TIM_B_PRE_LO   = 0;

    // bits that carry an interrupt source
    localparam logic [15:0] TIM_SRC_BITS   = 16'hFFB0;
    // bits of the mask register that exist (bit 6 reads zero)
    localparam logic [15:0] TIM_MASK_BITS  = 16'hFFBF;

    // reset values
    localparam logic [15:0] TIM_MASK_RST   = 16'h0000;
    localparam logic [15:0] TIM_STAT_RST   = 16'h0000;
    localparam logic [15:0] TIM_IMASK_RST  = 16'h0000;

    // byte lanes
    localparam int          TIM_LANE_LO    = 0;
    localparam int          TIM_LANE_HI    = 1;

endpackage : tim_pkg

// ### rtl/tim_irq_mask.sv
// timer interrupt enable gating with wishbone register access
module tim_irq_mask
    import tim_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [TIM_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [TIM_DATA_W-1:0] wb_dat_i,
    output logic      [TIM_DATA_W-1:0] wb_dat_o,
    output logic                       wb_ack_o,
    // event flags from the flag logic
    input  wire logic                  shared_capture_compare_flag_i,
    input  wire logic [3:0]            compare_flag_i,
    input  wire logic [2:0]            capture_flag_i,
    input  wire logic                  counter_wrap_flag_i,
    input  wire logic                  accumulator_wrap_flag_i,
    input  wire logic                  accumulator_edge_flag_i,
    // requests to the interrupt arbitration
    output logic                       shared_capture_compare_req_o,
    output logic      [3:0]            compare_req_o,
    output logic      [2:0]            capture_req_o,
    output logic                       counter_wrap_req_o,
    output logic                       accumulator_wrap_req_o,
    output logic                       accumulator_edge_req_o,
    // first compare pin
    input  wire logic                  counter_clock_i,
    input  wire logic                  compare1_level_i,
    output logic                       first_compare_pin_o,
    // summary interrupt
    output logic                       irq_o
);

    logic [TIM_REG_W-1:0] timer_mask;
    logic [TIM_REG_W-1:0] next_timer_mask;
    logic [TIM_REG_W-1:0] irq_status;
    logic [TIM_REG_W-1:0] next_irq_status;
    logic [TIM_REG_W-1:0] irq_mask;
    logic [TIM_REG_W-1:0] next_irq_mask;
    logic [TIM_REG_W-1:0] flag_prev;
    logic [TIM_REG_W-1:0] req;
    logic [TIM_REG_W-1:0] next_req;
    logic [TIM_DATA_W-1:0] next_dat;
    logic                 next_ack;
    logic                 next_pin;
    logic                 next_irq;
    logic [TIM_REG_W-1:0] flags;
    logic [TIM_REG_W-1:0] wmask;
    logic                 access;
    logic                 wr;

    // gather the flags into the shared field layout
    always_comb begin
        flags                              = '0;
        flags[TIM_B_SHARED]                = shared_capture_compare_flag_i;
        flags[TIM_B_CMP_HI:TIM_B_CMP_LO]   = compare_flag_i;
        flags[TIM_B_CAP_HI:TIM_B_CAP_LO]   = capture_flag_i;
        flags[TIM_B_CWRAP]                 = counter_wrap_flag_i;
        flags[TIM_B_AWRAP]                 = accumulator_wrap_flag_i;
        flags[TIM_B_AEDGE]                 = accumulator_edge_flag_i;
    end

    // byte-lane write mask; ack is withheld for one cycle so each access is taken once
    always_comb begin
        access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wr     = access & wb_we_i;
        wmask  = {{8{wb_sel_i[TIM_LANE_HI]}}, {8{wb_sel_i[TIM_LANE_LO]}}};
    end

    // requests: enable AND flag for every source
    always_comb begin
        next_req = timer_mask & flags & TIM_SRC_BITS;
    end

    // registers and bus answer
    always_comb begin
        next_timer_mask = timer_mask;
        next_irq_mask   = irq_mask;
        next_ack        = access;
        next_dat        = '0;
        if (wr && wb_adr_i == TIM_OFF_MASK) begin
            next_timer_mask = ((timer_mask & ~wmask) | (wb_dat_i[TIM_REG_W-1:0] & wmask)) & TIM_MASK_BITS;
        end
        if (wr && wb_adr_i == TIM_OFF_IMASK) begin
            next_irq_mask = ((irq_mask & ~wmask) | (wb_dat_i[TIM_REG_W-1:0] & wmask)) & TIM_SRC_BITS;
        end
        if (access && !wb_we_i) begin
            unique case (wb_adr_i)
                TIM_OFF_MASK:  next_dat[TIM_REG_W-1:0] = timer_mask;
                TIM_OFF_STAT:  next_dat[TIM_REG_W-1:0] = irq_status;
                TIM_OFF_IMASK: next_dat[TIM_REG_W-1:0] = irq_mask;
                TIM_OFF_REQ:   next_dat[TIM_REG_W-1:0] = req;
                default:       next_dat = '0;
            endcase
        end
    end

    // sticky status: a rising flag sets its bit; the set beats a same-cycle clear
    always_comb begin
        next_irq_status = irq_status;
        if (wr && wb_adr_i == TIM_OFF_STAT) begin
            next_irq_status = irq_status & ~(wb_dat_i[TIM_REG_W-1:0] & wmask);
        end
        next_irq_status = next_irq_status | (flags & ~flag_prev & TIM_SRC_BITS);
        next_irq        = |(next_irq_status & irq_mask);
    end

    // the counter clock is a same-domain tick, so the pin toggles at most once per cycle
    always_comb begin
        next_pin = timer_mask[TIM_B_CLKOUT] ? counter_clock_i : compare1_level_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mask          <= TIM_MASK_RST;
            irq_status          <= TIM_STAT_RST;
            irq_mask            <= TIM_IMASK_RST;
            flag_prev           <= '0;
            req                 <= '0;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= '0;
            first_compare_pin_o <= 1'b0;
            irq_o               <= 1'b0;
        end else begin
            timer_mask          <= next_timer_mask;
            irq_status          <= next_irq_status;
            irq_mask            <= next_irq_mask;
            flag_prev           <= flags;
            req                 <= next_req;
            wb_ack_o            <= next_ack;
            wb_dat_o            <= next_dat;
            first_compare_pin_o <= next_pin;
            irq_o               <= next_irq;
        end
    end

    // request ports are slices of the registered request word
    always_comb begin
        shared_capture_compare_req_o = req[TIM_B_SHARED];
        compare_req_o                = req[TIM_B_CMP_HI:TIM_B_CMP_LO];
        capture_req_o                = req[TIM_B_CAP_HI:TIM_B_CAP_LO];
        counter_wrap_req_o           = req[TIM_B_CWRAP];
        accumulator_wrap_req_o       = req[TIM_B_AWRAP];
        accumulator_edge_req_o       = req[TIM_B_AEDGE];
    end

endmodule // tim_irq_mask

// ### dv/tim_irq_mask_properties.sv
// checker for the timer interrupt mask logic
module tim_irq_mask_chk
    import tim_pkg::*;
(
    // clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // flags and requests
    input wire logic        shared_capture_compare_flag_i,
    input wire logic [3:0]  compare_flag_i,
    input wire logic [2:0]  capture_flag_i,
    input wire logic        counter_wrap_flag_i,
    input wire logic        accumulator_wrap_flag_i,
    input wire logic        accumulator_edge_flag_i,
    input wire logic        shared_capture_compare_req_o,
    input wire logic [3:0]  compare_req_o,
    input wire logic [2:0]  capture_req_o,
    input wire logic        counter_wrap_req_o,
    input wire logic        accumulator_wrap_req_o,
    input wire logic        accumulator_edge_req_o,
    // first compare pin
    input wire logic        counter_clock_i,
    input wire logic        compare1_level_i,
    input wire logic        first_compare_pin_o
);
    // shadow of the mask word; it ignores wb_sel_i, but the bench writes the low lane alone once
    logic [15:0] m;
    logic [15:0] next_m;
    always_comb begin
        next_m = m;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == TIM_OFF_MASK) begin
            next_m = wb_dat_i[15:0];
        end
    end
    always_ff @(posedge clk_i) m <= rst_i ? 16'h0 : next_m;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_shr; shared_capture_compare_req_o == $past(m[15] & shared_capture_compare_flag_i); endproperty
    a_shr: assert property (p_shr) else $error("shared request wrong");
    property p_cmp; compare_req_o == $past(m[14:11] & compare_flag_i); endproperty
    a_cmp: assert property (p_cmp) else $error("compare request wrong");
    property p_cap; capture_req_o == $past(m[10:8] & capture_flag_i); endproperty
    a_cap: assert property (p_cap) else $error("capture request wrong");
    property p_cwr; (m[7] && counter_wrap_flag_i) |=> counter_wrap_req_o; endproperty
    a_cwr: assert property (p_cwr) else $error("counter wrap request missing");
    property p_awr; accumulator_wrap_req_o == $past(m[5] & accumulator_wrap_flag_i); endproperty
    a_awr: assert property (p_awr) else $error("accumulator wrap request wrong");
    property p_aed; !m[4] |=> !accumulator_edge_req_o; endproperty
    a_aed: assert property (p_aed) else $error("accumulator edge request not masked");
    property p_pin; first_compare_pin_o == $past(m[3] ? counter_clock_i : compare1_level_i); endproperty
    a_pin: assert property (p_pin) else $error("first compare pin wrong");
    property p_drop; $fell(counter_wrap_flag_i) |=> !counter_wrap_req_o; endproperty
    a_drop: assert property (p_drop) else $error("wrap request held after flag fell");
    c_cmp: cover property (compare_req_o == 4'hF);
    c_pin: cover property ($rose(first_compare_pin_o));
    c_wr: cover property (wb_ack_o && wb_we_i);
endmodule // tim_irq_mask_chk

bind tim_irq_mask tim_irq_mask_chk chk_u (.*);

// ### dv/test_timer_interrupt_mask_logic.sv
// testbench for the timer interrupt mask logic
module test_timer_interrupt_mask_logic
    import tim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h3, compare_flag_i, compare_req_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdq;
    logic [15:0] fl = 16'h0;
    logic [2:0]  capture_flag_i, capture_req_o;
    logic        counter_clock_i = 1'h0, compare1_level_i = 1'h0, wb_ack_o, first_compare_pin_o, irq_o;
    logic        shared_capture_compare_flag_i, counter_wrap_flag_i, accumulator_wrap_flag_i, accumulator_edge_flag_i;
    logic        shared_capture_compare_req_o, counter_wrap_req_o, accumulator_wrap_req_o, accumulator_edge_req_o;
    int          errors = 0, checks = 0;
    // flags laid out like the mask word
    assign {shared_capture_compare_flag_i, compare_flag_i, capture_flag_i, counter_wrap_flag_i} = fl[15:7];
    assign {accumulator_wrap_flag_i, accumulator_edge_flag_i} = fl[5:4];
    wire [31:0] rq = {16'h0, shared_capture_compare_req_o, compare_req_o, capture_req_o, counter_wrap_req_o,
                      1'h0, accumulator_wrap_req_o, accumulator_edge_req_o, 4'h0};
    tim_irq_mask dut_u (.*);
    initial forever #12.5 clk_i = ~clk_i;
    task automatic stop_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++n < 20);
        if (wb_ack_o !== 1'h1) begin
            errors++;
            stop_test();
        end else begin
            rdq = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask
    task automatic rc(input string n, input logic [3:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(n, rdq, e);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        rc("mask", TIM_OFF_MASK, 32'h0);
        rc("irq mask", TIM_OFF_IMASK, 32'h0);
        // low lane only: the upper byte must stay clear
        wb_sel_i <= 4'h1;
        bus(1'h1, TIM_OFF_MASK, 32'hFFFF);
        wb_sel_i <= 4'h3;
        rc("mask low lane", TIM_OFF_MASK, 32'h00BF);
        bus(1'h1, TIM_OFF_MASK, 32'hFFFF);
        rc("mask", TIM_OFF_MASK, {16'h0, TIM_MASK_BITS});
        fl <= 16'hFFFF;
        repeat (3) @(posedge clk_i);
        chk("requests", rq, {16'h0, TIM_SRC_BITS});
        // one enable at a time: every other source must stay quiet
        for (int i = 4; i < 16; i++) begin
            if (i == 6) continue;
            bus(1'h1, TIM_OFF_MASK, 32'h1 << i);
            repeat (2) @(posedge clk_i);
            chk("requests", rq, 32'h1 << i);
            rc("request word", TIM_OFF_REQ, 32'h1 << i);
        end
        bus(1'h1, TIM_OFF_MASK, 32'hFFFF);
        fl <= 16'h0;
        {counter_clock_i, compare1_level_i} <= 2'h2;
        repeat (3) @(posedge clk_i);
        chk("requests", rq, 32'h0);
        chk("pin", first_compare_pin_o, 32'h1);
        bus(1'h1, TIM_OFF_MASK, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("pin", first_compare_pin_o, 32'h0);
        rc("status", TIM_OFF_STAT, {16'h0, TIM_SRC_BITS});
        chk("irq", irq_o, 32'h0);
        bus(1'h1, TIM_OFF_IMASK, 32'h10);
        repeat (3) @(posedge clk_i);
        chk("irq", irq_o, 32'h1);
        bus(1'h1, TIM_OFF_STAT, 32'h10);
        repeat (3) @(posedge clk_i);
        chk("irq", irq_o, 32'h0);
        rc("status", TIM_OFF_STAT, 32'hFFA0);
        bus(1'h1, TIM_OFF_REQ, 32'hFFFF);
        rc("request word", TIM_OFF_REQ, 32'h0);
        rc("unmapped", 4'h2, 32'h0);
        stop_test();
    end
endmodule // test_timer_interrupt_mask_logic
